// File: common/bsdc_map.svh
// register map, field positions, reset values and code limits
`ifndef BSDC_MAP_SVH
`define BSDC_MAP_SVH

// register indices; byte address is four times the index
`define BSDC_IDX_SLEEP 16'h405E
`define BSDC_IDX_SCALE 16'h405F
`define BSDC_IDX_STATUS 16'h40F0
`define BSDC_ADDR_W 18
`define BSDC_ADDR_SLEEP {`BSDC_IDX_SLEEP, 2'b00}
`define BSDC_ADDR_SCALE {`BSDC_IDX_SCALE, 2'b00}
`define BSDC_ADDR_STATUS {`BSDC_IDX_STATUS, 2'b00}

// field positions
`define BSDC_SLOT_HI 15
`define BSDC_SLOT_LO 13
`define BSDC_SRC_HI 12
`define BSDC_SRC_LO 11
`define BSDC_MODE_HI 9
`define BSDC_MODE_LO 8
`define BSDC_VSEL_HI 6
`define BSDC_VSEL_LO 0

// reset values
`define BSDC_SLOT_RST 3'h0
`define BSDC_MODE_RST 2'h3
`define BSDC_VSEL_RST 7'h00
`define BSDC_SRC_RST 2'h0

// slot codes and timeslots
`define BSDC_SLOT_TR5 3'h0
`define BSDC_SLOT_TR3 3'h6
`define BSDC_SLOT_TR1 3'h7
`define BSDC_DIS_BASE 3'h6
`define BSDC_TS1 3'h1
`define BSDC_TS3 3'h3
`define BSDC_TS5 3'h5

// voltage code limits
`define BSDC_VMIN_CODE 7'h08
`define BSDC_VSAT_CODE 7'h68
`define BSDC_FAST_MAX 7'h48

`endif

// File: common/bsdc_pkg.sv
// types shared by the sleep and scaling register block
package bsdc_pkg;
`include "bsdc_map.svh"

	typedef enum logic [1:0] {
		MODE_FCCM = 2'h0,
		MODE_AUTO = 2'h1,
		MODE_LDO  = 2'h2,
		MODE_HYST = 2'h3
	} bsdc_mode_t;

	typedef enum logic [1:0] {
		SRC_OFF = 2'h0,
		SRC_ON  = 2'h1,
		SRC_HW1 = 2'h2,
		SRC_HW2 = 2'h3
	} bsdc_src_t;

	typedef enum logic [2:0] {
		SQ_IDLE = 3'b001,
		SQ_WAIT = 3'b010,
		SQ_DONE = 3'b100
	} bsdc_seq_t;

	typedef struct packed {
		logic [2:0] slot;
		bsdc_mode_t mode;
		logic [6:0] vsel;
	} bsdc_sleep_t;

	typedef struct packed {
		bsdc_src_t  src;
		logic [6:0] vsel;
	} bsdc_scale_t;

	typedef struct packed {
		logic                    psel;
		logic                    penable;
		logic                    pwrite;
		logic [`BSDC_ADDR_W-1:0] paddr;
		logic [31:0]             pwdata;
		logic [3:0]              pstrb;
	} bsdc_apb_req_t;

	typedef struct packed {
		logic [6:0] code;
		logic [6:0] step;
		bsdc_mode_t mode;
		logic       dvsActive;
		logic       fastLimitExceeded;
	} bsdc_target_t;

endpackage

// File: logic/bsdc_vcode_decode.sv
// voltage code to 12.5 mV step index decoder
`timescale 1ns/1ps
`include "bsdc_map.svh"

module bsdc_vcode_decode
	import bsdc_pkg::*;
(
	input  wire logic [6:0] code,      // voltage code
	output logic      [6:0] step,      // steps above 0.6 V
	output logic            overFast   // above 4 MHz limit
);

	// clamp low codes to 0.6 V and high codes to 1.8 V
	always_comb begin
		if (code <= `BSDC_VMIN_CODE) begin
			step = 7'h00;
		end else if (code >= `BSDC_VSAT_CODE) begin
			step = `BSDC_VSAT_CODE - `BSDC_VMIN_CODE;
		end else begin
			step = code - `BSDC_VMIN_CODE;
		end
	end

	// flag only; software keeps within limit
	assign overFast = (code > `BSDC_FAST_MAX);

endmodule // bsdc_vcode_decode

// File: logic/bsdc_apb_slave.sv
// apb slave front end: decode, read capture, error answer
`timescale 1ns/1ps
`include "bsdc_map.svh"

module bsdc_apb_slave
	import bsdc_pkg::*;
(
	input  wire logic          clk_sys,  // system clock
	input  wire logic          nrst,     // async reset, low
	input  wire bsdc_apb_req_t apbReq,   // apb request
	input  wire logic [15:0]   rdWord,   // selected register
	output logic      [31:0]   prdata,   // read data
	output logic               pready,   // transfer done
	output logic               pslverr,  // unmapped address
	output logic      [2:0]    regSel,   // status, scale, sleep
	output logic               wrEn      // write this edge
);

	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic        err_q;
	logic        err_d;
	logic        setup;
	logic        mapped;

	// address decode, one-hot
	always_comb begin
		regSel = 3'h0;
		case (apbReq.paddr)
			`BSDC_ADDR_SLEEP:  regSel = 3'h1;
			`BSDC_ADDR_SCALE:  regSel = 3'h2;
			`BSDC_ADDR_STATUS: regSel = 3'h4;
			default:           regSel = 3'h0;
		endcase
	end

	assign mapped = |regSel;
	assign setup  = apbReq.psel & ~apbReq.penable;

	// capture read data and error in setup phase
	always_comb begin
		prdata_d = prdata_q;
		err_d    = err_q;
		if (setup) begin
			prdata_d = (mapped & ~apbReq.pwrite) ?
				{16'h0000, rdWord} : 32'h0000_0000;
			err_d    = ~mapped;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			err_q    <= err_d;
		end
	end

	// zero wait states in access phase
	assign pready  = apbReq.psel & apbReq.penable;
	assign pslverr = pready & err_q;
	assign prdata  = prdata_q;
	assign wrEn    = pready & apbReq.pwrite & mapped;

	// unmapped access answers with error
	property p_unmapped_err;
		@(posedge clk_sys) disable iff (!nrst)
		(setup && !mapped) ##1 (apbReq.psel && apbReq.penable)
			|-> pslverr;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped access without error");

endmodule // bsdc_apb_slave

// File: logic/bsdc_top.sv
// second buck converter sleep and voltage scaling registers
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "bsdc_map.svh"

module bsdc_top
	import bsdc_pkg::*;
(
	input  wire logic          clk_sys,                // system clock
	input  wire logic          nrst,                   // async reset, low
	input  wire bsdc_apb_req_t apbReq,                 // apb request
	output logic      [31:0]   prdata,                 // apb read data
	output logic               pready,                 // apb ready
	output logic               pslverr,                // apb error
	input  wire logic          sleepSeqActive,         // sleep sequence
	input  wire logic [2:0]    sleepSlotNow,           // current slot
	input  wire logic          hwEnableAssigned,       // hw enable owner
	input  wire logic          hwControlActive,        // hw control on
	input  wire logic          hwControlVoltageChoice, // 1 = sleep code
	input  wire logic [6:0]    onStateVoltageCode,     // on code
	input  wire bsdc_mode_t    onStateMode,            // on mode
	input  wire logic          hwScalingInputOne,      // pin, async
	input  wire logic          hwScalingInputTwo,      // pin, async
	output logic               sleepConditionActive,   // in sleep
	output logic               converterDisableReq,    // switch off
	output bsdc_target_t       target                  // converter target
);

	bsdc_sleep_t  sleepReg_q;
	bsdc_sleep_t  sleepReg_d;
	bsdc_scale_t  scaleReg_q;
	bsdc_scale_t  scaleReg_d;
	bsdc_seq_t    seq_q;
	bsdc_seq_t    seq_d;
	logic         sleepCond_q;
	logic         sleepCond_d;
	logic         disableReq_q;
	logic         disableReq_d;
	bsdc_target_t target_q;
	bsdc_target_t target_d;
	logic [1:0]   pinMeta_q;
	logic [1:0]   pinSync_q;
	logic [1:0]   pinRaw;
	logic [2:0]   regSel;
	logic         wrEn;
	logic [15:0]  rdWord;
	logic [15:0]  curWord;
	logic [15:0]  newWord;
	logic [2:0]   slotTarget;
	logic         slotDisables;
	logic         dvsActive;
	logic [6:0]   code_d;
	logic [6:0]   step_d;
	logic         overFast_d;

	// bus front end
	bsdc_apb_slave u_apb (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.apbReq  (apbReq),
		.rdWord  (rdWord),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.regSel  (regSel),
		.wrEn    (wrEn)
	);

	// two-flop synchronisers for scaling pins
	assign pinRaw = {hwScalingInputTwo, hwScalingInputOne};
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_sync
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					pinMeta_q[i] <= 1'b0;
					pinSync_q[i] <= 1'b0;
				end else begin
					pinMeta_q[i] <= pinRaw[i];
					pinSync_q[i] <= pinMeta_q[i];
				end
			end
		end
	endgenerate

	// readback words, reserved bits zero
	always_comb begin
		case (regSel)
			3'h1: rdWord = {sleepReg_q.slot, 3'h0, sleepReg_q.mode,
				1'b0, sleepReg_q.vsel};
			3'h2: rdWord = {3'h0, scaleReg_q.src, 4'h0,
				scaleReg_q.vsel};
			3'h4: rdWord = {1'b0, target_q.code, 1'b0, seq_q,
				target_q.fastLimitExceeded, target_q.dvsActive,
				disableReq_q, sleepCond_q};
			default: rdWord = 16'h0000;
		endcase
	end

	// byte lanes merge into the selected word
	assign curWord = (regSel == 3'h1) ? rdWord :
		(regSel == 3'h2) ? rdWord : 16'h0000;
	assign newWord = {
		apbReq.pstrb[1] ? apbReq.pwdata[15:8] : curWord[15:8],
		apbReq.pstrb[0] ? apbReq.pwdata[7:0] : curWord[7:0]};

	// register writes
	always_comb begin
		sleepReg_d = sleepReg_q;
		scaleReg_d = scaleReg_q;
		if (wrEn && regSel == 3'h1) begin
			sleepReg_d.mode = bsdc_mode_t'(
				newWord[`BSDC_MODE_HI:`BSDC_MODE_LO]);
			sleepReg_d.vsel = newWord[`BSDC_VSEL_HI:`BSDC_VSEL_LO];
			sleepReg_d.slot = newWord[`BSDC_SLOT_HI:`BSDC_SLOT_LO];
		end
		if (wrEn && regSel == 3'h2) begin
			scaleReg_d.src = bsdc_src_t'(
				newWord[`BSDC_SRC_HI:`BSDC_SRC_LO]);
			scaleReg_d.vsel = newWord[`BSDC_VSEL_HI:`BSDC_VSEL_LO];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sleepReg_q.slot <= `BSDC_SLOT_RST;
			sleepReg_q.mode <= bsdc_mode_t'(`BSDC_MODE_RST);
			sleepReg_q.vsel <= `BSDC_VSEL_RST;
			scaleReg_q.src  <= bsdc_src_t'(`BSDC_SRC_RST);
			scaleReg_q.vsel <= `BSDC_VSEL_RST;
		end else begin
			sleepReg_q <= sleepReg_d;
			scaleReg_q <= scaleReg_d;
		end
	end

	// slot code to timeslot and action
	always_comb begin
		slotDisables = 1'b0;
		case (sleepReg_q.slot)
			`BSDC_SLOT_TR5: slotTarget = `BSDC_TS5;
			`BSDC_SLOT_TR3: slotTarget = `BSDC_TS3;
			`BSDC_SLOT_TR1: slotTarget = `BSDC_TS1;
			default: begin
				// disable slot five down to one
				slotTarget   = `BSDC_DIS_BASE - sleepReg_q.slot;
				// hw enable turns disable into sleep
				slotDisables = ~hwEnableAssigned;
			end
		endcase
	end

	// sleep sequence tracker
	always_comb begin
		seq_d        = seq_q;
		sleepCond_d  = sleepCond_q;
		disableReq_d = disableReq_q;
		case (seq_q)
			SQ_IDLE: begin
				if (sleepSeqActive) begin
					seq_d = SQ_WAIT;
				end
			end
			SQ_WAIT: begin
				if (!sleepSeqActive) begin
					seq_d = SQ_IDLE;
				end else if (sleepSlotNow == slotTarget) begin
					seq_d        = SQ_DONE;
					disableReq_d = slotDisables;
					sleepCond_d  = ~slotDisables;
				end
			end
			SQ_DONE: begin
				if (!sleepSeqActive) begin
					seq_d        = SQ_IDLE;
					sleepCond_d  = 1'b0;
					disableReq_d = 1'b0;
				end
			end
			default: begin
				seq_d        = SQ_IDLE;
				sleepCond_d  = 1'b0;
				disableReq_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			seq_q        <= SQ_IDLE;
			sleepCond_q  <= 1'b0;
			disableReq_q <= 1'b0;
		end else begin
			seq_q        <= seq_d;
			sleepCond_q  <= sleepCond_d;
			disableReq_q <= disableReq_d;
		end
	end

	always_comb begin
		case (scaleReg_q.src)
			SRC_ON:  dvsActive = 1'b1;
			SRC_HW1: dvsActive = pinSync_q[0];
			SRC_HW2: dvsActive = pinSync_q[1];
			default: dvsActive = 1'b0;
		endcase
	end

	// target code and mode selection
	always_comb begin
		code_d          = onStateVoltageCode;
		target_d        = target_q;
		target_d.mode   = onStateMode;
		if (sleepCond_q) begin
			target_d.mode = sleepReg_q.mode;
			code_d        = sleepReg_q.vsel;
		end else if (hwControlActive) begin
			code_d = hwControlVoltageChoice ?
				sleepReg_q.vsel : onStateVoltageCode;
		end
		if (dvsActive) begin
			code_d = scaleReg_q.vsel;
		end
		target_d.code              = code_d;
		target_d.step              = step_d;
		target_d.dvsActive         = dvsActive;
		target_d.fastLimitExceeded = overFast_d;
	end

	bsdc_vcode_decode u_dec (
		.code     (code_d),
		.step     (step_d),
		.overFast (overFast_d)
	);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			target_q <= '0;
		end else begin
			target_q <= target_d;
		end
	end

	assign target               = target_q;
	assign sleepConditionActive = sleepCond_q;
	assign converterDisableReq  = disableReq_q;

	// checks on the sleep sequence and target
	property p_slot5_trans;
		@(posedge clk_sys) disable iff (!nrst)
		(seq_q == SQ_WAIT && sleepSeqActive && sleepSlotNow == 3'h5
			&& sleepReg_q.slot == 3'h0)
			|=> sleepCond_q && !disableReq_q;
	endproperty
	a_slot5_trans: assert property (p_slot5_trans)
		else $error("code 000 missed slot 5 transition");

	property p_disable_slot;
		@(posedge clk_sys) disable iff (!nrst)
		(seq_q == SQ_WAIT && sleepSeqActive && !hwEnableAssigned
			&& sleepReg_q.slot == 3'h2 && sleepSlotNow == 3'h4)
			|=> disableReq_q && !sleepCond_q;
	endproperty
	a_disable_slot: assert property (p_disable_slot)
		else $error("code 010 did not disable in slot 4");

	property p_slot1_trans;
		@(posedge clk_sys) disable iff (!nrst)
		(seq_q == SQ_WAIT && sleepSeqActive && sleepReg_q.slot == 3'h7
			&& sleepSlotNow != 3'h1) |=> !sleepCond_q;
	endproperty
	a_slot1_trans: assert property (p_slot1_trans)
		else $error("code 111 acted outside slot 1");

	property p_hw_sleep;
		@(posedge clk_sys) disable iff (!nrst)
		(seq_q == SQ_WAIT && sleepSeqActive && hwEnableAssigned
			&& sleepReg_q.slot == 3'h5 && sleepSlotNow == 3'h1)
			|=> sleepCond_q && !disableReq_q;
	endproperty
	a_hw_sleep: assert property (p_hw_sleep)
		else $error("hw enable code did not enter sleep");

	property p_sleep_mode;
		@(posedge clk_sys) disable iff (!nrst)
		sleepCond_q |=> target_q.mode == $past(sleepReg_q.mode);
	endproperty
	a_sleep_mode: assert property (p_sleep_mode)
		else $error("sleep mode not applied");

	property p_sleep_wr;
		@(posedge clk_sys) disable iff (!nrst)
		(wrEn && regSel == 3'h1 && apbReq.pstrb[0])
			|=> sleepReg_q.vsel == $past(apbReq.pwdata[6:0]);
	endproperty
	a_sleep_wr: assert property (p_sleep_wr)
		else $error("sleep code write lost");

	property p_step_sat;
		@(posedge clk_sys) disable iff (!nrst)
		(target_q.code >= 7'h68 |-> target_q.step == 7'h60) and
		(target_q.code <= 7'h08 |-> target_q.step == 7'h00);
	endproperty
	a_step_sat: assert property (p_step_sat)
		else $error("code decode out of range");

	property p_dvs_on;
		@(posedge clk_sys) disable iff (!nrst)
		(scaleReg_q.src == SRC_ON) ##1 (scaleReg_q.src == SRC_ON)
			|-> target_q.dvsActive
			&& target_q.code == $past(scaleReg_q.vsel);
	endproperty
	a_dvs_on: assert property (p_dvs_on)
		else $error("scaling code not applied");

	property p_hwc_choice;
		@(posedge clk_sys) disable iff (!nrst)
		(hwControlActive && hwControlVoltageChoice && !sleepCond_q
			&& scaleReg_q.src == SRC_OFF)
			|=> target_q.code == $past(sleepReg_q.vsel);
	endproperty
	a_hwc_choice: assert property (p_hwc_choice)
		else $error("hw choice did not pick sleep code");

	property p_hw1_pin;
		@(posedge clk_sys) disable iff (!nrst)
		(scaleReg_q.src == SRC_HW1 && !pinSync_q[0])
			|=> !target_q.dvsActive;
	endproperty
	a_hw1_pin: assert property (p_hw1_pin)
		else $error("hw input 1 low but scaling active");

endmodule // bsdc_top

// File: testbench/tb_buck_sleep_dvs_control.sv
// self-checking bench for the sleep and scaling register block
`timescale 1ns/1ps
`include "bsdc_map.svh"

module tb_buck_sleep_dvs_control
	import bsdc_pkg::*;
;
	logic          clk_sys;
	logic          nrst;
	bsdc_apb_req_t req;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	logic          seqAct;
	logic [2:0]    slotNow;
	logic          hwEn;
	logic          hwCtl;
	logic          hwChoice;
	logic [6:0]    onCode;
	bsdc_mode_t    onMode;
	logic          hw_scaling_input_one;
	logic          hw_scaling_input_two;
	logic          sleepCond;
	logic          disReq;
	bsdc_target_t  target;
	logic [31:0]   rd;
	logic          err;
	int            n_errors;
	int            samples_checked;
	int            seed;
	int            mSleep;
	int            mScale;
	int            i;
	int            s;
	int            c;
	int            e;
	int            sl;
	logic [6:0]    codes [8] = '{7'h00, 7'h08, 7'h09, 7'h48,
		7'h49, 7'h67, 7'h68, 7'h7F};

	bsdc_top i_bsdc_top (
		.clk_sys                (clk_sys),
		.nrst                   (nrst),
		.apbReq                 (req),
		.prdata                 (prdata),
		.pready                 (pready),
		.pslverr                (pslverr),
		.sleepSeqActive         (seqAct),
		.sleepSlotNow           (slotNow),
		.hwEnableAssigned       (hwEn),
		.hwControlActive        (hwCtl),
		.hwControlVoltageChoice (hwChoice),
		.onStateVoltageCode     (onCode),
		.onStateMode            (onMode),
		.hwScalingInputOne      (hw_scaling_input_one),
		.hwScalingInputTwo      (hw_scaling_input_two),
		.sleepConditionActive   (sleepCond),
		.converterDisableReq    (disReq),
		.target                 (target)
	);

	// clock at 40 MHz
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// verdict and end of run
	task automatic test_done;
		if (n_errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// compare one value
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// apb transfer, waits for pready under a bound
	task automatic apb(input logic wr, input logic [`BSDC_ADDR_W-1:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		req <= '{1'b1, 1'b0, wr, a, d, 4'hF};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k == 16) begin
			n_errors++;
			test_done;
		end
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// register write with model update
	task automatic wr_reg(input int sel, input logic [15:0] d);
		apb(1'b1, sel ? `BSDC_ADDR_SCALE : `BSDC_ADDR_SLEEP, {16'h0, d});
		if (sel) mScale = d & 16'h187F;
		else mSleep = d & 16'hE37F;
	endtask

	// register read against model
	task automatic rd_chk(input int sel);
		apb(1'b0, sel ? `BSDC_ADDR_SCALE : `BSDC_ADDR_SLEEP, 32'h0);
		chk_word(rd, sel ? mScale : mSleep);
	endtask

	// target code, step and flags against decode model
	task automatic chk_tgt(input logic [6:0] c7, input logic dv);
		int st;
		st = c7 <= 7'h08 ? 0 : (c7 >= 7'h68 ? 96 : c7 - 8);
		chk_word({25'h0, target.code}, {25'h0, c7});
		chk_word({25'h0, target.step}, st);
		chk_word({31'h0, target.dvsActive}, {31'h0, dv});
		chk_word({31'h0, target.fastLimitExceeded}, c7 > 7'h48);
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		test_done;
	end

	// main sequence
	initial begin
		seed = 32'h4594;
		n_errors = 0;
		samples_checked = 0;
		req = '0;
		{seqAct, hwEn, hwCtl, hwChoice, hw_scaling_input_one, hw_scaling_input_two} = 6'h00;
		slotNow = 3'h0;
		onCode = 7'h2A;
		onMode = MODE_AUTO;
		nrst = 1'b0;
		mSleep = 32'h0300;
		mScale = 0;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		rd_chk(0);
		rd_chk(1);
		// random writes and readback
		for (i = 0; i < 8; i++) begin
			wr_reg(i % 2, 16'($random(seed)));
			rd_chk(i % 2);
		end
		// unmapped place refuses and leaves the sleep register alone
		apb(1'b1, `BSDC_ADDR_SCALE + 18'h4, 32'hFFFF);
		chk_word({31'h0, err}, 32'h1);
		apb(1'b0, `BSDC_ADDR_SCALE + 18'h4, 32'h0);
		chk_word(rd, 32'h0);
		rd_chk(0);
		// scaling code decode across boundaries
		for (i = 0; i < 8; i++) begin
			wr_reg(1, {3'h0, SRC_ON, 4'h0, codes[i]});
			repeat (3) @(posedge clk_sys);
			chk_tgt(codes[i], 1'b1);
		end
		// hardware inputs steer scaling, other input ignored
		for (s = 2; s < 4; s++) begin
			wr_reg(1, {3'h0, 2'(s), 4'h0, 7'h30});
			if (s == 2) hw_scaling_input_two <= 1'b1;
			else hw_scaling_input_one <= 1'b1;
			repeat (5) @(posedge clk_sys);
			chk_word({31'h0, target.dvsActive}, 32'h0);
			if (s == 2) hw_scaling_input_one <= 1'b1;
			else hw_scaling_input_two <= 1'b1;
			repeat (5) @(posedge clk_sys);
			chk_tgt(7'h30, 1'b1);
			hw_scaling_input_one <= 1'b0;
			hw_scaling_input_two <= 1'b0;
		end
		wr_reg(1, 16'h0030);
		// hardware control voltage choice
		onCode <= 7'($random(seed));
		hwCtl <= 1'b1;
		wr_reg(0, {3'h0, 3'h0, MODE_LDO, 1'b0, 7'h55});
		for (c = 0; c < 2; c++) begin
			hwChoice <= c[0];
			repeat (3) @(posedge clk_sys);
			chk_word(target.code, c ? 7'h55 : onCode);
		end
		hwCtl <= 1'b0;
		// every slot code through a sleep sequence
		for (i = 0; i < 16; i++) begin
			s = i % 8;
			hwEn <= i[3];
			wr_reg(0, {3'(s), 3'h0, 2'(s), 1'b0, 7'h11});
			e = s == 0 ? 5 : (s == 6 ? 3 : (s == 7 ? 1 : 6 - s));
			sl = s == 0 || s > 5 || i > 7;
			seqAct <= 1'b1;
			slotNow <= 3'h0;
			@(posedge clk_sys);
			for (c = 1; c <= 5; c++) begin
				slotNow <= 3'(c);
				repeat (2) @(posedge clk_sys);
				chk_word({31'h0, sleepCond}, sl && c >= e);
				chk_word({31'h0, disReq}, !sl && c >= e);
			end
			@(posedge clk_sys);
			if (sl) begin
				chk_word({25'h0, target.code}, 32'h11);
				chk_word({30'h0, target.mode}, s % 4);
			end
			seqAct <= 1'b0;
			repeat (3) @(posedge clk_sys);
			chk_word({30'h0, sleepCond, disReq}, 32'h0);
		end
		// status word: idle, scaling, disable and sleep flags clear, fast flag per on-state code, on-state code shown
		apb(1'b0, `BSDC_ADDR_STATUS, 32'h0);
		chk_word(rd, {17'h0, onCode, 1'b0, 3'b001, onCode > 7'h48, 3'h0});
		test_done;
	end
endmodule // tb_buck_sleep_dvs_control
